// >>> clkgen_pkg.sv
// Constants, register map and carrier types of the serial clock block
package clkgen_pkg;
   localparam int DIV_W = 12;
   localparam logic [DIV_W-1:0] DIV_RESET = 12'h000;
   // Register byte addresses
   localparam logic [11:0] ADDR_DIV_LOW = 12'h000;
   localparam logic [11:0] ADDR_DIV_HIGH = 12'h004;
   localparam logic [11:0] ADDR_CTRL = 12'h008;
   localparam logic [11:0] ADDR_FRAME = 12'h00C;
   localparam logic [11:0] ADDR_STATUS = 12'h010;
   localparam logic [11:0] ADDR_PARITY = 12'h014;
   // Control register fields
   localparam int CTRL_DOUBLE = 0;
   localparam int CTRL_SYNC = 1;
   localparam int CTRL_DIR = 2;
   localparam int CTRL_POL = 3;
   localparam int CTRL_NINTH = 4;
   // Frame register fields
   localparam int FRM_SIZE_LSB = 0;
   localparam int FRM_PAR_LSB = 3;
   localparam int FRM_STOP = 5;
   // Divide ratios
   localparam logic [3:0] DIVR_NORMAL = 4'hF;
   localparam logic [3:0] DIVR_DOUBLE = 4'h7;
   localparam logic [3:0] DIVR_SYNC = 4'h1;
   // Character size codes; 4..6 are reserved and act as 8
   localparam logic [2:0] SIZE_9 = 3'h7;
   localparam logic [2:0] SIZE_BASE = 3'h0;
   localparam logic [3:0] BITS_BASE = 4'h5;
   localparam logic [3:0] BITS_8 = 4'h8;
   localparam logic [3:0] BITS_9 = 4'h9;
   // Parity modes
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_RSVD = 2'h1;
   localparam logic [1:0] PAR_EVEN = 2'h2;
   localparam logic [1:0] PAR_ODD = 2'h3;

   typedef enum logic [3:0] {
      MODE_ASYNC = 4'b0001,
      MODE_DOUBLE = 4'b0010,
      MODE_MASTER = 4'b0100,
      MODE_SLAVE = 4'b1000
   } clk_mode_e;

   typedef struct packed {
      logic double_speed_select;
      logic sync_mode_select;
      logic xfer_clock_pin_direction;
      logic sync_clock_polarity;
      logic transmit_ninth_bit;
   } ctrl_s;

   typedef struct packed {
      logic [2:0] character_size_field;
      logic [1:0] parity_mode_field;
      logic stop_bit_select;
   } frame_s;

   typedef struct packed {
      logic [3:0] data_bits;
      logic parity_on;
      logic parity_odd;
      logic two_stops;
   } format_s;
endpackage

// >>> clock_sync.sv
// Two-stage synchroniser with edge detection for the external clock
`timescale 1ns/1ps
module clock_sync (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // Pin side
   input wire logic pin_in,
   // Detected edges
   output logic rise,
   output logic fall
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // Only sync_reg reads meta_reg
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else if (clk_en) begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign rise = sync_reg & ~last_reg;
   assign fall = ~sync_reg & last_reg;
endmodule

// >>> serial_clock_gen.sv
// Baud generator, clock modes and frame format of the serial channel
`timescale 1ns/1ps
// Function
// - Internal clock async/master, pin clock slave
// - Counter reloads at zero or low write
// - Tick at fosc divided by divisor+1
// - Twelve-bit divisor in high and low registers
// - Transmit divides tick by 16, 8, 2
// - Receive phase machine 16, 8, 2 states
// - Double speed only affects async mode
// - Double speed halves receive samples to 8
// - Slave clock synchronised, edge detected, delayed two
// - Sync mode drives or accepts clock pin
// - Sample edge opposite to change edge
// - Polarity picks change and sample edges
// - Start, 5-9 data LSB first, parity, stops
// - Line idles high between frames
// - One shared format for both directions
// - Only first stop bit checked for error
// - Parity is data XOR, inverted for odd
// - Pin direction picks master or slave
// - Size seven means nine bits, ninth separate
module serial_clock_gen (
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Transfer clock pin
   input wire logic xck_in,
   output logic xck_out,
   output logic xck_oe,
   // Strobes to the transmit and receive paths
   output logic tx_tick,
   output logic rx_tick,
   output logic tx_change,
   output logic rx_sample,
   output clkgen_pkg::format_s format,
   // Parity helper for the data paths
   input wire logic [8:0] parity_data
);
   import clkgen_pkg::*;

   logic [DIV_W-1:0] divisor_reg;
   logic [DIV_W-1:0] count_reg;
   ctrl_s ctrl_reg;
   frame_s frame_reg;
   clk_mode_e mode;
   logic [3:0] divr;
   logic [3:0] tx_div_reg;
   logic [3:0] rx_phase_reg;
   logic gen_tick;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic ext_rise;
   logic ext_fall;
   logic xck_reg;
   logic xck_oe_reg;
   logic tx_tick_reg;
   logic rx_tick_reg;
   logic tx_change_reg;
   logic rx_sample_reg;
   logic parity_reg;
   format_s format_reg;
   format_s format_next;
   logic change_edge;
   logic sample_edge;
   logic parity_next;

   // APB decode, zero wait states
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & ~penable & ~pwrite;
   always_comb begin
      unique case (paddr)
         ADDR_DIV_LOW, ADDR_DIV_HIGH, ADDR_CTRL,
         ADDR_FRAME, ADDR_STATUS, ADDR_PARITY: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         divisor_reg <= DIV_RESET;
         ctrl_reg <= '0;
         frame_reg <= '0;
      end else if (clk_en && wr_en) begin
         unique case (paddr)
            ADDR_DIV_LOW: divisor_reg[7:0] <= pwdata[7:0];
            ADDR_DIV_HIGH: divisor_reg[DIV_W-1:8] <= pwdata[3:0];
            ADDR_CTRL: ctrl_reg <= {pwdata[CTRL_DOUBLE],
               pwdata[CTRL_SYNC], pwdata[CTRL_DIR],
               pwdata[CTRL_POL], pwdata[CTRL_NINTH]};
            ADDR_FRAME: frame_reg <= {pwdata[FRM_SIZE_LSB +: 3],
               pwdata[FRM_PAR_LSB +: 2], pwdata[FRM_STOP]};
            default: ;
         endcase
      end
   end

   // Read data registered in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pslverr <= 1'b0;
         pready <= 1'b0;
      end else if (clk_en) begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok;
         if (rd_en) begin
            prdata <= '0;
            unique case (paddr)
               ADDR_DIV_LOW: prdata[7:0] <= divisor_reg[7:0];
               ADDR_DIV_HIGH: prdata[3:0] <= divisor_reg[DIV_W-1:8];
               ADDR_CTRL: prdata[4:0] <= {ctrl_reg.transmit_ninth_bit,
                  ctrl_reg.sync_clock_polarity,
                  ctrl_reg.xfer_clock_pin_direction,
                  ctrl_reg.sync_mode_select,
                  ctrl_reg.double_speed_select};
               ADDR_FRAME: prdata[5:0] <= {frame_reg.stop_bit_select,
                  frame_reg.parity_mode_field,
                  frame_reg.character_size_field};
               ADDR_STATUS: prdata[DIV_W-1:0] <= count_reg;
               ADDR_PARITY: prdata[0] <= parity_reg;
               default: ;
            endcase
         end
      end
   end

   // Mode select; pin direction picks master or slave
   always_comb begin
      if (ctrl_reg.sync_mode_select) begin
         mode = ctrl_reg.xfer_clock_pin_direction ? MODE_MASTER
                                                  : MODE_SLAVE;
      end else if (ctrl_reg.double_speed_select) begin
         mode = MODE_DOUBLE;
      end else begin
         mode = MODE_ASYNC;
      end
   end

   always_comb begin
      unique case (mode)
         MODE_ASYNC: divr = DIVR_NORMAL;
         MODE_DOUBLE: divr = DIVR_DOUBLE;
         default: divr = DIVR_SYNC;
      endcase
   end

   // Baud down-counter
   assign gen_tick = (count_reg == '0);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= DIV_RESET;
      end else if (clk_en) begin
         if (wr_en && paddr == ADDR_DIV_LOW) begin
            count_reg <= {divisor_reg[DIV_W-1:8], pwdata[7:0]};
         end else if (gen_tick) begin
            count_reg <= divisor_reg;
         end else begin
            count_reg <= count_reg - 12'h001;
         end
      end
   end

   // Slave clock path
   clock_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .pin_in(xck_in),
      .rise(ext_rise),
      .fall(ext_fall)
   );

   // Transmit divider and receive phase counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_div_reg <= '0;
         rx_phase_reg <= '0;
      end else if (clk_en && gen_tick && mode != MODE_SLAVE) begin
         tx_div_reg <= (tx_div_reg >= divr) ? 4'h0
                                            : tx_div_reg + 4'h1;
         rx_phase_reg <= (rx_phase_reg >= divr) ? 4'h0
                                                : rx_phase_reg + 4'h1;
      end
   end

   // Master clock toggles every tick: period 2 ticks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xck_reg <= 1'b0;
         xck_oe_reg <= 1'b0;
      end else if (clk_en) begin
         xck_oe_reg <= (mode == MODE_MASTER);
         if (mode != MODE_MASTER) begin
            xck_reg <= ctrl_reg.sync_clock_polarity;
         end else if (gen_tick) begin
            xck_reg <= ~xck_reg;
         end
      end
   end

   // Edge roles by polarity; slave uses synchronised edges
   always_comb begin
      change_edge = 1'b0;
      sample_edge = 1'b0;
      unique case (mode)
         MODE_MASTER: begin
            change_edge = gen_tick &
               (xck_reg == ctrl_reg.sync_clock_polarity);
            sample_edge = gen_tick &
               (xck_reg != ctrl_reg.sync_clock_polarity);
         end
         MODE_SLAVE: begin
            change_edge = ctrl_reg.sync_clock_polarity ? ext_fall
                                                       : ext_rise;
            sample_edge = ctrl_reg.sync_clock_polarity ? ext_rise
                                                       : ext_fall;
         end
         default: ;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_tick_reg <= 1'b0;
         rx_tick_reg <= 1'b0;
         tx_change_reg <= 1'b0;
         rx_sample_reg <= 1'b0;
      end else if (clk_en) begin
         // Strobe keeps running while idle so frames can follow at once
         tx_tick_reg <= gen_tick && tx_div_reg == divr
                        && mode != MODE_SLAVE;
         rx_tick_reg <= gen_tick && mode != MODE_SLAVE;
         tx_change_reg <= change_edge;
         rx_sample_reg <= sample_edge;
      end else begin
         tx_tick_reg <= 1'b0;
         rx_tick_reg <= 1'b0;
         tx_change_reg <= 1'b0;
         rx_sample_reg <= 1'b0;
      end
   end

   // Shared frame format
   always_comb begin
      // Second stop only lengthens transmit; receive checks the first
      format_next.two_stops = frame_reg.stop_bit_select;
      format_next.parity_on = frame_reg.parity_mode_field[1];
      format_next.parity_odd = frame_reg.parity_mode_field == PAR_ODD;
      if (frame_reg.character_size_field == SIZE_9) begin
         format_next.data_bits = BITS_9;
      end else if (frame_reg.character_size_field > 3'h3) begin
         format_next.data_bits = BITS_8;
      end else begin
         format_next.data_bits = BITS_BASE +
            {1'b0, frame_reg.character_size_field};
      end
   end

   // Parity over the active data bits
   always_comb begin
      parity_next = format_next.parity_odd;
      for (int i = 0; i < 9; i++) begin
         if (i < 8 && 4'(i) < format_next.data_bits) begin
            parity_next = parity_next ^ parity_data[i];
         end
      end
      if (format_next.data_bits == BITS_9) begin
         parity_next = parity_next ^ ctrl_reg.transmit_ninth_bit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         format_reg <= '0;
         parity_reg <= 1'b0;
      end else if (clk_en) begin
         format_reg <= format_next;
         parity_reg <= parity_next;
      end
   end

   assign xck_out = xck_reg;
   assign xck_oe = xck_oe_reg;
   assign tx_tick = tx_tick_reg;
   assign rx_tick = rx_tick_reg;
   assign tx_change = tx_change_reg;
   assign rx_sample = rx_sample_reg;
   assign format = format_reg;

   // Checks
   counter_reload_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      clk_en && gen_tick && !(wr_en && paddr == ADDR_DIV_LOW)
      |=> count_reg == $past(divisor_reg))
      else $error("counter did not reload");
   slave_no_tick_a: assert property (@(posedge pclk)
      disable iff (!presetn) mode == MODE_SLAVE |=> !rx_tick)
      else $error("tick in slave mode");
   tick_at_zero_a: assert property (@(posedge pclk)
      disable iff (!presetn) clk_en && gen_tick && mode != MODE_SLAVE
      |=> rx_tick)
      else $error("missing tick");
   xck_drive_a: assert property (@(posedge pclk)
      disable iff (!presetn) clk_en && mode == MODE_MASTER
      |=> xck_oe)
      else $error("clock pin not driven");
   edge_excl_a: assert property (@(posedge pclk)
      disable iff (!presetn) !(tx_change && rx_sample))
      else $error("change and sample together");
   nine_bits_a: assert property (@(posedge pclk)
      disable iff (!presetn) clk_en &&
      frame_reg.character_size_field == SIZE_9
      |=> format.data_bits == BITS_9)
      else $error("nine bit size wrong");
   tx_div_a: assert property (@(posedge pclk)
      disable iff (!presetn) tx_tick |-> $past(tx_div_reg) == $past(divr))
      else $error("transmit divide wrong");
   double_async_a: assert property (@(posedge pclk)
      disable iff (!presetn) ctrl_reg.sync_mode_select
      |-> mode inside {MODE_MASTER, MODE_SLAVE})
      else $error("double speed in sync");
   rx_phase_a: assert property (@(posedge pclk)
      disable iff (!presetn) clk_en && gen_tick && mode != MODE_SLAVE
      && rx_phase_reg == divr |=> rx_phase_reg == '0)
      else $error("receive phase did not wrap");
endmodule

// >>> xck_source.sv
// Remote clock source that drives the transfer clock pin in slave mode
`timescale 1ns/1ps
module xck_source #(
   parameter int HALF_NS = 500
) (
   // Control from the bench
   input wire logic run,
   input wire logic idle_level,
   // Pin
   output logic xck
);
   // Ten system cycles a period, far under a quarter of fosc for margin
   initial xck = 1'b0;
   always begin
      if (run) begin
         #HALF_NS xck = ~xck;
      end else begin
         #10 xck = idle_level;
      end
   end
endmodule

// >>> serial_clock_and_frame_format_bench.sv
// Testbench for the serial clock generator and frame format block
`timescale 1ns/1ps
module serial_clock_and_frame_format_bench;
   import clkgen_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic clk_en = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [8:0] parity_data = 9'h000;
   logic [31:0] prdata;
   logic pready, pslverr, xck_out, xck_oe;
   logic tx_tick, rx_tick, tx_change, rx_sample;
   format_s format;
   logic part_run = 1'b0;
   logic part_idle = 1'b0;
   logic part_xck;
   wire xck_in = xck_oe ? xck_out : part_xck;
   logic xq = 1'b0;
   logic [31:0] rdat;
   logic rerr;
   int error_cnt = 0;
   int n_checks = 0;
   logic [5:0] frm [6] = '{6'h00, 6'h11, 6'h3A, 6'h0B, 6'h2F, 6'h14};
   logic [3:0] ctl [4] = '{4'h0, 4'h1, 4'h6, 4'h7};
   int tdiv [4] = '{16, 8, 2, 2};

   always #50 pclk = ~pclk;
   always @(posedge pclk) xq <= xck_out;

   serial_clock_gen serial_clock_gen_inst (.pclk(pclk), .presetn(presetn),
      .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .xck_in(xck_in), .xck_out(xck_out),
      .xck_oe(xck_oe), .tx_tick(tx_tick), .rx_tick(rx_tick),
      .tx_change(tx_change), .rx_sample(rx_sample), .format(format),
      .parity_data(parity_data));
   xck_source xck_source_inst (.run(part_run), .idle_level(part_idle),
      .xck(part_xck));

   task automatic stop_test();
      $display("Checks %0d, errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic chk1(string name, logic seen, logic exp);
      check(name, {31'h0000_0000, seen}, {31'h0000_0000, exp});
   endtask

   // Request held until pready is sampled high at a rising edge
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 16) begin
         error_cnt++;
         stop_test();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic set_div(logic [11:0] v);
      apb(1'b1, ADDR_DIV_HIGH, {28'h000_0000, v[11:8]});
      apb(1'b1, ADDR_DIV_LOW, {24'h00_0000, v[7:0]});
   endtask

   function automatic logic sig(int w);
      case (w)
         0: return rx_tick;
         1: return tx_tick;
         2: return tx_change;
         3: return rx_sample;
         default: return xck_out ^ xq;
      endcase
   endfunction

   task automatic wait_pulse(int w, output int n);
      n = 0;
      do begin
         @(posedge pclk);
         #1;
         n++;
      end while (sig(w) !== 1'b1 && n < 5000);
      if (n >= 5000) begin
         error_cnt++;
         stop_test();
      end
   endtask

   // First pulses after a change of mode may be irregular, so skip two
   task automatic period(string name, int w, int exp);
      int n;
      wait_pulse(w, n);
      wait_pulse(w, n);
      wait_pulse(w, n);
      check(name, n, exp);
   endtask

   initial begin
      int n;
      int k;
      logic [3:0] b;
      logic [2:0] s;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      check("count", rdat, 32'h0000_0000);
      set_div(12'h105);
      apb(1'b0, ADDR_DIV_HIGH, 32'h0000_0000);
      check("div_high", rdat[3:0], 32'h0000_0001);
      apb(1'b0, ADDR_DIV_LOW, 32'h0000_0000);
      check("div_low", rdat[7:0], 32'h0000_0005);
      period("rx_tick", 0, 262);
      apb(1'b0, 12'h018, 32'h0000_0000);
      chk1("pslverr", rerr, 1'b1);
      set_div(12'h0FF);
      apb(1'b1, ADDR_DIV_LOW, 32'h0000_0003);
      wait_pulse(0, n);
      chk1("reload", n <= 8, 1'b1);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, ADDR_CTRL, {28'h000_0000, ctl[i]});
         period("tx_tick", 1, 4 * tdiv[i]);
         period("rx_tick", 0, 4);
         chk1("xck_oe", xck_oe, i >= 2);
         if (i >= 2) period("xck_out", 4, 4);
      end
      @(posedge pclk);
      clk_en <= 1'b0;
      k = 0;
      repeat (2) @(posedge pclk);
      repeat (30) begin
         @(posedge pclk);
         #1;
         if (rx_tick === 1'b1) k++;
      end
      check("frozen", k, 0);
      clk_en <= 1'b1;
      for (int p = 0; p < 2; p++) begin
         apb(1'b1, ADDR_CTRL, {28'h000_0000, p[0], 3'h2});
         part_idle <= p[0];
         // Old master clock and idle level must clear the synchroniser
         repeat (8) @(posedge pclk);
         chk1("xck_oe", xck_oe, 1'b0);
         part_run <= 1'b1;
         k = 0;
         repeat (200) begin
            @(posedge pclk);
            #1;
            if (tx_change === 1'b1) begin
               k++;
               chk1("change_lvl", xck_in, ~p[0]);
            end
            if (rx_sample === 1'b1) chk1("sample_lvl", xck_in, p[0]);
         end
         chk1("changes", k > 0, 1'b1);
         part_run <= 1'b0;
      end
      foreach (frm[i]) begin
         apb(1'b1, ADDR_FRAME, {26'h000_0000, frm[i]});
         @(posedge pclk);
         #1;
         s = frm[i][2:0];
         b = s < 3'h4 ? 4'h5 + {1'b0, s} : (s == 3'h7 ? 4'h9 : 4'h8);
         check("format", {25'h000_0000, format}, {25'h000_0000, b,
            frm[i][4], frm[i][4:3] == 2'h3, frm[i][5]});
      end
      for (int i = 0; i < 8; i++) begin
         s = i[0] ? 3'h7 : 3'h3;
         apb(1'b1, ADDR_CTRL, {27'h000_0000, i[2], 4'h0});
         apb(1'b1, ADDR_FRAME, {26'h000_0000, 1'b0, 1'b1, i[1], s});
         // Ninth bit comes from the control bit, never the data word
         parity_data <= i[2] ? 9'h0C7 : 9'h1A5;
         apb(1'b0, ADDR_PARITY, 32'h0000_0000);
         chk1("parity", rdat[0], ^parity_data[7:0] ^ (i[0] & i[2])
            ^ i[1]);
      end
      stop_test();
   end
endmodule
